// [cfm_map.vh]
`ifndef CFM_MAP_VH
`define CFM_MAP_VH
// Register byte offsets.
`define CFM_A_CTRL      8'h00
`define CFM_A_LOSLIM    8'h04
`define CFM_A_XLOSLIM   8'h08
`define CFM_A_OOFWIN    8'h0c
`define CFM_A_OOFEXP    8'h10
`define CFM_A_LOLTHR    8'h14
`define CFM_A_LOLTMR    8'h18
`define CFM_A_PPSTHR    8'h1c
`define CFM_A_PPSCNT    8'h20
`define CFM_A_INSEL     8'h24
`define CFM_A_LIVE      8'h28
`define CFM_A_STICKY    8'h2c
`define CFM_A_MASK      8'h30
`define CFM_A_RAMP      8'h34
// Control register fields.
`define CFM_C_KEEP      0
`define CFM_C_ZSEL      1
`define CFM_C_PPS       4
`define CFM_C_HITLESS   5
`define CFM_C_RAMP      8
`define CFM_C_LOSDIS    11
`define CFM_C_PRECDIS   16
`define CFM_C_FASTDIS   17
// Status layout: signal loss 4:0, frequency 8:5, standard lock 11:9, pulse lock 12.
`define CFM_S_LOS       0
`define CFM_S_OOF       5
`define CFM_S_LOL       9
`define CFM_S_PPS       12
`define CFM_NSTAT       13
// Reset values.
`define CFM_R_CTRL      32'h0000_0000
`define CFM_R_LOSLIM    32'h0404_0404
`define CFM_R_XLOSLIM   8'h04
`define CFM_R_OOFWIN    32'h0010_0060
`define CFM_R_OOFEXP    16'h0100
`define CFM_R_LOLTHR    32'h0001_000a
`define CFM_R_LOLTMR    16'h0010
`define CFM_R_PPSTHR    32'h0010_0040
`define CFM_R_PPSCNT    32'h0004_0004
`define CFM_R_RAMP      16'h0001
// Timing: zero-reference edges per precise gate, fast monitor ratio (1/250 = 4000 ppm).
`define CFM_GATE        16'd256
`define CFM_FAST_DIV    8'd250
`endif

// [cfm_clock_fault_monitor.v]
// Summary of operation
// - Hitless loop absorbs switch phase difference
// - Hitless enable per loop, loop D's off in pulse mode
// - Input ramp shares holdover exit ramp rate
// - Glitch-free switch, no runt output pulses
// - Lock loss held during pull-in
// - Gapped clock raises no loss fault
// - Loss and frequency monitors cover listed inputs
// - Period loss monitor, own sensitivity, disable
// - Live bits follow, sticky bits latch
// - Crystal loss stops outputs unless configured
// - Precise and fast monitors combined, disableable
// - Precise window in fine steps
// - Precise monitor hysteresis near boundary
// - Selectable zero-offset frequency reference
// - Fast monitor flags 4000 ppm change
// - Per-loop lock monitor and fault pins
// - Set and clear lock thresholds
// - Optional delay before lock restores
// - Loop A, C and D fault pins follow live lock state
// - Pulse loop lock from phase error
// - Consecutive-cycle trigger and clear counters
// - Interrupt pin on unmasked status (bits 9 and 12 ignored in pulse mode), cleared by sticky
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "cfm_map.vh"
module cfm_clock_fault_monitor (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [2:0]  general_clock_inputs,
    input  wire        main_reference_input,
    input  wire        crystal_input,
    input  wire [47:0] loop_freq_diff,
    input  wire [15:0] loop_d_phase_err,
    input  wire        loop_d_pps_tick,
    output reg         loop_a_lock_fault_n,
    output reg         loop_c_lock_fault_n,
    output reg         loop_d_lock_fault_n,
    output reg         lock_fault_pin_n,
    output reg         irq_n,
    output reg         outputs_enable,
    output reg  [2:0]  loop_hitless_en,
    output reg  [2:0]  loop_ramp_en,
    output reg  [15:0] ramp_rate,
    output reg  [5:0]  loop_input_sel,
    output reg  [2:0]  loop_switch
);
    reg  [31:0] ctrl_ff;
    reg  [31:0] loslim_ff;
    reg  [7:0]  xloslim_ff;
    reg  [31:0] oofwin_ff;
    reg  [15:0] oofexp_ff;
    reg  [31:0] lolthr_ff;
    reg  [15:0] loltmr_ff;
    reg  [31:0] ppsthr_ff;
    reg  [31:0] ppscnt_ff;
    reg  [5:0]  insel_ff;
    reg  [12:0] sticky_ff;
    reg  [12:0] mask_ff;
    reg  [15:0] ramp_ff;
    reg  [15:0] gate_ff;
    wire [2:0]  lol_w;
    reg         pps_lol_ff;
    reg  [15:0] trig_cnt_ff;
    reg  [15:0] clr_cnt_ff;
    wire [4:0]  src_w = {crystal_input, main_reference_input, general_clock_inputs};
    wire [4:0]  edge_w;
    wire [4:0]  los_w;
    wire [3:0]  oof_w;
    wire [39:0] lim_w = {xloslim_ff, loslim_ff};
    wire        pps_mode = ctrl_ff[`CFM_C_PPS];
    wire        acc_w = psel & penable & pready;
    wire        wr_w = acc_w & pwrite;
    reg         zedge_w;
    reg         gate_end_w;
    reg  [31:0] rd_w;
    reg         hit_w;
    wire [12:0] live_w = {pps_lol_ff, lol_w, oof_w, los_w};

    always @* begin
        case (ctrl_ff[`CFM_C_ZSEL+2:`CFM_C_ZSEL])
            3'h1: zedge_w = edge_w[0];
            3'h2: zedge_w = edge_w[1];
            3'h3: zedge_w = edge_w[2];
            3'h4: zedge_w = edge_w[4];
            default: zedge_w = edge_w[3];
        endcase
        gate_end_w = zedge_w && (gate_ff == `CFM_GATE - 16'd1);
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_ff <= 16'h0000;
        end else if (ce && zedge_w) begin
            gate_ff <= gate_end_w ? 16'h0000 : gate_ff + 16'd1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_src
            reg [2:0]  sync_ff;
            reg        lvl_ff;
            reg        edge_ff;
            reg [15:0] per_ff;
            reg [15:0] last_ff;
            reg        los_ff;
            wire       agree_w = sync_ff[1] == sync_ff[2];
            wire [15:0] lim16_w = {4'h0, lim_w[8*i+7:8*i], 4'h0};
            // Second and third stages must agree before an edge counts; the first feeds only the second.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_ff <= 3'h0;
                    lvl_ff  <= 1'b0;
                    edge_ff <= 1'b0;
                    per_ff  <= 16'h0000;
                    last_ff <= 16'h0000;
                    los_ff  <= 1'b0;
                end else if (ce) begin
                    sync_ff <= {sync_ff[1:0], src_w[i]};
                    if (agree_w) begin
                        lvl_ff <= sync_ff[1];
                    end
                    edge_ff <= agree_w & sync_ff[1] & ~lvl_ff;
                    if (edge_ff) begin
                        per_ff  <= 16'h0000;
                        last_ff <= per_ff;
                    end else if (per_ff != 16'hffff) begin
                        per_ff <= per_ff + 16'd1;
                    end
                    if (ctrl_ff[`CFM_C_LOSDIS+i]) begin
                        los_ff <= 1'b0;
                    end else if (edge_ff) begin
                        los_ff <= 1'b0;
                    end else if (per_ff > lim16_w) begin
                        los_ff <= 1'b1;
                    end
                end
            end
            assign edge_w[i] = edge_ff;
            assign los_w[i]  = los_ff;
            if (i < 4) begin : g_oof
                reg  [15:0] ecnt_ff;
                reg         prec_ff;
                reg         fast_ff;
                reg         prev_ok_ff;
                reg  [15:0] prev_ff;
                wire [16:0] dev_w = {1'b0, ecnt_ff} - {1'b0, oofexp_ff};
                wire [15:0] mag_w = dev_w[16] ? (~dev_w[15:0] + 16'd1) : dev_w[15:0];
                wire [15:0] pd_w  = (last_ff > prev_ff) ? (last_ff - prev_ff) : (prev_ff - last_ff);
                wire [23:0] pdx_w = pd_w * `CFM_FAST_DIV;
                always @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        ecnt_ff    <= 16'h0000;
                        prec_ff    <= 1'b0;
                        fast_ff    <= 1'b0;
                        prev_ok_ff <= 1'b0;
                        prev_ff    <= 16'h0000;
                    end else if (ce) begin
                        if (gate_end_w) begin
                            ecnt_ff <= {15'h0000, edge_ff};
                        end else if (edge_ff && ecnt_ff != 16'hffff) begin
                            ecnt_ff <= ecnt_ff + 16'd1;
                        end
                        if (ctrl_ff[`CFM_C_PRECDIS]) begin
                            prec_ff <= 1'b0;
                        end else if (gate_end_w) begin
                            if (!prec_ff && mag_w > oofwin_ff[15:0]) begin
                                prec_ff <= 1'b1;
                            end else if (prec_ff && {1'b0, mag_w} + {1'b0, oofwin_ff[31:16]} <= {1'b0, oofwin_ff[15:0]}) begin
                                prec_ff <= 1'b0;
                            end
                        end
                        if (edge_ff) begin
                            prev_ff    <= last_ff;
                            prev_ok_ff <= 1'b1;
                        end
                        if (ctrl_ff[`CFM_C_FASTDIS]) begin
                            fast_ff <= 1'b0;
                        end else if (edge_ff && prev_ok_ff && last_ff != 16'h0000) begin
                            fast_ff <= pdx_w > {8'h00, prev_ff};
                        end
                    end
                end
                assign oof_w[i] = prec_ff | fast_ff;
            end
        end
    endgenerate

    genvar k;
    generate
        for (k = 0; k < 3; k = k + 1) begin : g_lol
            wire [15:0] fd_w = loop_freq_diff[16*k+15:16*k];
            reg         lol_ff;
            reg  [15:0] lol_tmr_ff;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lol_ff     <= 1'b1;
                    lol_tmr_ff <= 16'h0000;
                end else if (ce) begin
                    if (insel_ff[2*k+1:2*k] != loop_input_sel[2*k+1:2*k] || fd_w > lolthr_ff[15:0]) begin
                        lol_ff     <= 1'b1;
                        lol_tmr_ff <= 16'h0000;
                    end else if (lol_ff && fd_w < lolthr_ff[31:16]) begin
                        if (lol_tmr_ff >= loltmr_ff) begin
                            lol_ff <= 1'b0;
                        end else begin
                            lol_tmr_ff <= lol_tmr_ff + 16'd1;
                        end
                    end else begin
                        lol_tmr_ff <= 16'h0000;
                    end
                end
            end
            assign lol_w[k] = lol_ff;
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pps_lol_ff  <= 1'b0;
            trig_cnt_ff <= 16'h0000;
            clr_cnt_ff  <= 16'h0000;
        end else if (ce) begin
            if (!pps_mode) begin
                pps_lol_ff  <= 1'b0;
                trig_cnt_ff <= 16'h0000;
                clr_cnt_ff  <= 16'h0000;
            end else if (loop_d_pps_tick) begin
                if (!pps_lol_ff) begin
                    clr_cnt_ff <= 16'h0000;
                    if (loop_d_phase_err <= ppsthr_ff[15:0]) begin
                        trig_cnt_ff <= 16'h0000;
                    end else if (trig_cnt_ff + 16'd1 >= ppscnt_ff[15:0]) begin
                        pps_lol_ff  <= 1'b1;
                        trig_cnt_ff <= 16'h0000;
                    end else begin
                        trig_cnt_ff <= trig_cnt_ff + 16'd1;
                    end
                end else begin
                    trig_cnt_ff <= 16'h0000;
                    if (loop_d_phase_err >= ppsthr_ff[31:16]) begin
                        clr_cnt_ff <= 16'h0000;
                    end else if (clr_cnt_ff + 16'd1 >= ppscnt_ff[31:16]) begin
                        pps_lol_ff <= 1'b0;
                        clr_cnt_ff <= 16'h0000;
                    end else begin
                        clr_cnt_ff <= clr_cnt_ff + 16'd1;
                    end
                end
            end
        end
    end

    always @* begin
        hit_w = 1'b1;
        case (paddr)
            `CFM_A_CTRL:    rd_w = ctrl_ff;
            `CFM_A_LOSLIM:  rd_w = loslim_ff;
            `CFM_A_XLOSLIM: rd_w = {24'h000000, xloslim_ff};
            `CFM_A_OOFWIN:  rd_w = oofwin_ff;
            `CFM_A_OOFEXP:  rd_w = {16'h0000, oofexp_ff};
            `CFM_A_LOLTHR:  rd_w = lolthr_ff;
            `CFM_A_LOLTMR:  rd_w = {16'h0000, loltmr_ff};
            `CFM_A_PPSTHR:  rd_w = ppsthr_ff;
            `CFM_A_PPSCNT:  rd_w = ppscnt_ff;
            `CFM_A_INSEL:   rd_w = {26'h0000000, insel_ff};
            `CFM_A_LIVE:    rd_w = {19'h00000, live_w};
            `CFM_A_STICKY:  rd_w = {19'h00000, sticky_ff};
            `CFM_A_MASK:    rd_w = {19'h00000, mask_ff};
            `CFM_A_RAMP:    rd_w = {16'h0000, ramp_ff};
            default: begin
                rd_w  = 32'h00000000;
                hit_w = 1'b0;
            end
        endcase
    end

    // Answers one cycle into the access phase; data and error are settled in the setup cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata     <= 32'h00000000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            ctrl_ff    <= `CFM_R_CTRL;
            loslim_ff  <= `CFM_R_LOSLIM;
            xloslim_ff <= `CFM_R_XLOSLIM;
            oofwin_ff  <= `CFM_R_OOFWIN;
            oofexp_ff  <= `CFM_R_OOFEXP;
            lolthr_ff  <= `CFM_R_LOLTHR;
            loltmr_ff  <= `CFM_R_LOLTMR;
            ppsthr_ff  <= `CFM_R_PPSTHR;
            ppscnt_ff  <= `CFM_R_PPSCNT;
            insel_ff   <= 6'h00;
            mask_ff    <= 13'h0000;
            ramp_ff    <= `CFM_R_RAMP;
            sticky_ff  <= 13'h0000;
        end else if (ce) begin
            pready  <= psel & ~penable;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_w : 32'h00000000;
            pslverr <= psel & ~penable & ~hit_w;
            if (wr_w) begin
                case (paddr)
                    `CFM_A_CTRL:    ctrl_ff    <= {14'h0000, pwdata[17:0]};
                    `CFM_A_LOSLIM:  loslim_ff  <= pwdata;
                    `CFM_A_XLOSLIM: xloslim_ff <= pwdata[7:0];
                    `CFM_A_OOFWIN:  oofwin_ff  <= pwdata;
                    `CFM_A_OOFEXP:  oofexp_ff  <= pwdata[15:0];
                    `CFM_A_LOLTHR:  lolthr_ff  <= pwdata;
                    `CFM_A_LOLTMR:  loltmr_ff  <= pwdata[15:0];
                    `CFM_A_PPSTHR:  ppsthr_ff  <= pwdata;
                    `CFM_A_PPSCNT:  ppscnt_ff  <= pwdata;
                    `CFM_A_INSEL:   insel_ff   <= pwdata[5:0];
                    `CFM_A_MASK:    mask_ff    <= pwdata[12:0];
                    `CFM_A_RAMP:    ramp_ff    <= pwdata[15:0];
                    default: ;
                endcase
            end
            sticky_ff <= (sticky_ff & ~((wr_w && paddr == `CFM_A_STICKY) ? pwdata[12:0] : 13'h0000)) | live_w;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_a_lock_fault_n <= 1'b0;
            loop_c_lock_fault_n <= 1'b0;
            loop_d_lock_fault_n <= 1'b0;
            lock_fault_pin_n    <= 1'b0;
            irq_n               <= 1'b1;
            outputs_enable      <= 1'b0;
            loop_hitless_en     <= 3'h0;
            loop_ramp_en        <= 3'h0;
            ramp_rate           <= 16'h0000;
            loop_input_sel      <= 6'h00;
            loop_switch         <= 3'h0;
        end else if (ce) begin
            loop_a_lock_fault_n <= ~lol_w[0];
            loop_c_lock_fault_n <= ~lol_w[1];
            loop_d_lock_fault_n <= ~(pps_mode ? pps_lol_ff : lol_w[2]);
            lock_fault_pin_n    <= ~(los_w[3] | oof_w[3]);
            irq_n <= ~|(sticky_ff & ~mask_ff & ~(pps_mode ? 13'h1200 : 13'h0000));
            outputs_enable <= ~los_w[4] | ctrl_ff[`CFM_C_KEEP];
            loop_hitless_en <= ctrl_ff[`CFM_C_HITLESS+2:`CFM_C_HITLESS] & {~pps_mode, 2'b11};
            loop_ramp_en <= ctrl_ff[`CFM_C_RAMP+2:`CFM_C_RAMP];
            ramp_rate    <= ramp_ff;
            loop_input_sel <= insel_ff;
            loop_switch    <= {insel_ff[5:4] != loop_input_sel[5:4],
                               insel_ff[3:2] != loop_input_sel[3:2],
                               insel_ff[1:0] != loop_input_sel[1:0]};
        end
    end
endmodule // cfm_clock_fault_monitor

// [cfm_checker.sv]
`timescale 1ns/1ps
`include "cfm_map.vh"
module cfm_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        ce,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [2:0]  general_clock_inputs,
    input wire        main_reference_input,
    input wire        crystal_input,
    input wire [47:0] loop_freq_diff,
    input wire [15:0] loop_d_phase_err,
    input wire        loop_d_pps_tick,
    input wire        loop_a_lock_fault_n,
    input wire        loop_c_lock_fault_n,
    input wire        loop_d_lock_fault_n,
    input wire        lock_fault_pin_n,
    input wire        irq_n,
    input wire        outputs_enable,
    input wire [2:0]  loop_hitless_en,
    input wire [2:0]  loop_ramp_en,
    input wire [15:0] ramp_rate,
    input wire [5:0]  loop_input_sel,
    input wire [2:0]  loop_switch
);
    wire        wr_done = psel && penable && pready && pwrite;
    wire        ctl_wr  = wr_done && paddr == `CFM_A_CTRL;
    wire        irq_wr  = ctl_wr || (wr_done && (paddr == `CFM_A_STICKY || paddr == `CFM_A_MASK));
    logic [31:0] wd1_ff;
    logic [31:0] wd2_ff;
    logic        keep_ff;
    // The write data is piped so checks two edges later see the word that was written.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd1_ff <= 32'h0;
            wd2_ff <= 32'h0;
            keep_ff <= 1'b0;
        end else begin
            wd1_ff <= pwdata;
            wd2_ff <= wd1_ff;
            if (ctl_wr) keep_ff <= pwdata[`CFM_C_KEEP];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_pulse: assert property (psel && !penable && ce |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    chk_err_unmapped: assert property (psel && !penable && paddr > `CFM_A_RAMP |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_ramp_copy: assert property (wr_done && paddr == `CFM_A_RAMP |-> ##2 ramp_rate == wd2_ff[15:0])
        else $error("ramp rate not taken from ramp register");
    chk_hitless_copy: assert property (ctl_wr && !pwdata[4] |-> ##2 loop_hitless_en == wd2_ff[7:5])
        else $error("hitless enables differ from control");
    chk_hitless_pulse: assert property (ctl_wr && pwdata[4] |-> ##2 !loop_hitless_en[2])
        else $error("hitless enabled in pulse mode");
    chk_output_keep: assert property (keep_ff && $past(keep_ff) |-> outputs_enable)
        else $error("outputs stopped although kept on");
    chk_switch_lock: assert property (loop_switch[0] |=> !loop_a_lock_fault_n [*8])
        else $error("lock fault released during pull-in");
    chk_irq_release: assert property ($rose(irq_n) |-> $past(irq_wr) || $past(irq_wr, 2) || $past(irq_wr, 3))
        else $error("interrupt released without a clear");
endmodule // cfm_checker
bind cfm_clock_fault_monitor cfm_checker i_cfm_checker (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .general_clock_inputs(general_clock_inputs), .main_reference_input(main_reference_input),
    .crystal_input(crystal_input), .loop_freq_diff(loop_freq_diff), .loop_d_phase_err(loop_d_phase_err),
    .loop_d_pps_tick(loop_d_pps_tick), .loop_a_lock_fault_n(loop_a_lock_fault_n),
    .loop_c_lock_fault_n(loop_c_lock_fault_n), .loop_d_lock_fault_n(loop_d_lock_fault_n),
    .lock_fault_pin_n(lock_fault_pin_n), .irq_n(irq_n), .outputs_enable(outputs_enable),
    .loop_hitless_en(loop_hitless_en), .loop_ramp_en(loop_ramp_en), .ramp_rate(ramp_rate),
    .loop_input_sel(loop_input_sel), .loop_switch(loop_switch));

// [cfm_clock_sources.sv]
`timescale 1ns/1ps
module cfm_clock_sources #(
    parameter int HALF_NS = 150
) (
    input  wire logic [4:0] run,
    input  wire logic       gap,
    output logic [2:0]      general_clock_inputs,
    output logic            main_reference_input,
    output logic            crystal_input
);
    logic [4:0] lvl_ff;
    int         half_cnt;
    // A stopped source holds its level, as a dead oscillator would.
    initial begin
        lvl_ff = 5'h00;
        half_cnt = 0;
        forever begin
            #(HALF_NS);
            half_cnt = (half_cnt + 1) % 16;
            lvl_ff = lvl_ff ^ (run & {4'hf, !(gap && half_cnt < 2)});
        end
    end
    assign general_clock_inputs = lvl_ff[2:0];
    assign main_reference_input = lvl_ff[3];
    assign crystal_input = lvl_ff[4];
endmodule // cfm_clock_sources

// [cfm_tb.sv]
`timescale 1ns/1ps
`include "cfm_map.vh"
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        pps_tick, irq_n, oe, gap;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0]  gclk, hit, ren, sw;
    logic        rclk, xclk;
    logic [3:0]  fault_n;
    logic [4:0]  run;
    logic [47:0] fdiff;
    logic [15:0] perr, rrate, rs;
    logic [5:0]  isel;
    logic [31:0] mdl [0:13];
    logic [31:0] rst [0:13];
    logic [31:0] wmask [0:13];
    int          err_total, samples_checked;
    cfm_clock_fault_monitor i_cfm_clock_fault_monitor (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .general_clock_inputs(gclk), .main_reference_input(rclk), .crystal_input(xclk),
        .loop_freq_diff(fdiff), .loop_d_phase_err(perr), .loop_d_pps_tick(pps_tick),
        .loop_a_lock_fault_n(fault_n[0]), .loop_c_lock_fault_n(fault_n[1]), .loop_d_lock_fault_n(fault_n[2]),
        .lock_fault_pin_n(fault_n[3]), .irq_n(irq_n), .outputs_enable(oe), .loop_hitless_en(hit),
        .loop_ramp_en(ren), .ramp_rate(rrate), .loop_input_sel(isel), .loop_switch(sw));
    cfm_clock_sources i_cfm_clock_sources (.run(run), .gap(gap), .general_clock_inputs(gclk),
        .main_reference_input(rclk), .crystal_input(xclk));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic tally_and_finish();
        if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n == 50) err_total++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
        if (a < 8'h38) mdl[a[7:2]] = d & wmask[a[7:2]];
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic xe);
        apb(a, 1'b0, 32'h0);
        check(q & m, x);
        check_pin(e, xe);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            pps_tick <= 1'b1;
            @(posedge pclk);
            pps_tick <= 1'b0;
            cyc(4);
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #1_000_000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        {presetn, psel, penable, pwrite, pps_tick, gap} = 6'h00;
        {paddr, pwdata, fdiff, perr} = '0;
        run = 5'h1f;
        rs = 16'd49441;
        rst = '{`CFM_R_CTRL, `CFM_R_LOSLIM, 32'(`CFM_R_XLOSLIM), `CFM_R_OOFWIN, 32'(`CFM_R_OOFEXP),
            `CFM_R_LOLTHR, 32'(`CFM_R_LOLTMR), `CFM_R_PPSTHR, `CFM_R_PPSCNT, 0, 0, 0, 0, 32'(`CFM_R_RAMP)};
        wmask = '{32'h3ffff, '1, 32'hff, '1, 32'hffff, '1, 32'hffff, '1, '1, 32'h3f, 0, 0, 32'h1fff, 32'hffff};
        mdl = rst;
        cyc(6);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 14; i++) if (i < 10 || i > 11) rd(8'(i * 4), '1, mdl[i], 1'b0);
        for (int i = 0; i < 14; i++) if (i < 10 || i > 11) begin
            rs = lfsr_next(rs);
            wr(8'(i * 4), {rs, ~rs} | 32'h10);
        end
        for (int i = 0; i < 14; i++) if (i < 10 || i > 11) rd(8'(i * 4), '1, mdl[i], 1'b0);
        for (int i = 0; i < 14; i++) if (i < 10 || i > 11) wr(8'(i * 4), rst[i]);
        rd(8'h38, '1, 32'h0, 1'b1);
        wr(`CFM_A_STICKY, 32'h1fff);
        wr(`CFM_A_MASK, 32'h1fef);
        cyc(2);
        check_pin(irq_n, 1'b1);
        run <= 5'h1e;
        cyc(200);
        rd(`CFM_A_LIVE, 32'h1, 32'h1, 1'b0);
        rd(`CFM_A_STICKY, 32'h1, 32'h1, 1'b0);
        run <= 5'h1f;
        cyc(200);
        rd(`CFM_A_LIVE, 32'h1, 32'h0, 1'b0);
        rd(`CFM_A_STICKY, 32'h1, 32'h1, 1'b0);
        wr(`CFM_A_STICKY, 32'h1);
        rd(`CFM_A_STICKY, 32'h1, 32'h0, 1'b0);
        wr(`CFM_A_CTRL, 32'h7e0);
        cyc(2);
        check({26'h0, ren, hit}, 32'h3f);
        wr(`CFM_A_CTRL, 32'h800);
        run <= 5'h1e;
        cyc(200);
        rd(`CFM_A_LIVE, 32'h1, 32'h0, 1'b0);
        run <= 5'h1f;
        gap <= 1'b1;
        wr(`CFM_A_CTRL, 32'h0);
        cyc(400);
        rd(`CFM_A_LIVE, 32'h1, 32'h0, 1'b0);
        gap <= 1'b0;
        run <= 5'h0f;
        cyc(200);
        check_pin(oe, 1'b0);
        check_pin(irq_n, 1'b0);
        rd(`CFM_A_LIVE, 32'h10, 32'h10, 1'b0);
        wr(`CFM_A_CTRL, 32'h1);
        cyc(3);
        check_pin(oe, 1'b1);
        run <= 5'h1f;
        cyc(200);
        check_pin(irq_n, 1'b0);
        wr(`CFM_A_STICKY, 32'h10);
        cyc(3);
        check_pin(irq_n, 1'b1);
        wr(`CFM_A_CTRL, 32'h0);
        check({28'h0, fault_n}, 32'hf);
        for (int l = 0; l < 3; l++) begin
            fdiff[l * 16 +: 16] <= 16'd100;
            cyc(5);
            check_pin(fault_n[l], 1'b0);
            fdiff[l * 16 +: 16] <= 16'd5;
            cyc(40);
            check_pin(fault_n[l], 1'b0);
            fdiff[l * 16 +: 16] <= 16'd0;
            cyc(8);
            check_pin(fault_n[l], 1'b0);
            cyc(40);
            check_pin(fault_n[l], 1'b1);
            fdiff[l * 16 +: 16] <= 16'd5;
            cyc(10);
            check_pin(fault_n[l], 1'b1);
            rd(`CFM_A_STICKY, 32'h200 << l, 32'h200 << l, 1'b0);
        end
        fdiff <= '0;
        wr(`CFM_A_INSEL, 32'h1);
        cyc(2);
        check({26'h0, isel}, 32'h1);
        check_pin(fault_n[0], 1'b0);
        cyc(40);
        check_pin(fault_n[0], 1'b1);
        wr(`CFM_A_CTRL, 32'hf0);
        tick(6);
        check_pin(fault_n[2], 1'b1);
        perr <= 16'h0100;
        tick(3);
        check_pin(fault_n[2], 1'b1);
        tick(1);
        check_pin(fault_n[2], 1'b0);
        rd(`CFM_A_LIVE, 32'h1000, 32'h1000, 1'b0);
        perr <= 16'h0000;
        tick(3);
        check_pin(fault_n[2], 1'b0);
        tick(1);
        check_pin(fault_n[2], 1'b1);
        presetn <= 1'b0;
        cyc(2);
        check({26'h0, irq_n, oe, fault_n}, 32'h20);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`CFM_A_CTRL, '1, 32'h0, 1'b0);
        tally_and_finish();
    end
endmodule // tb
